// ---- hw/bwsr_defines.svh ----
`ifndef BWSR_DEFINES_SVH
`define BWSR_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------------
`define BWSR_OFS_IO_SEC       8'h1c
`define BWSR_OFS_MEM          8'h20
`define BWSR_OFS_PREF         8'h24
`define BWSR_OFS_IO_UPPER     8'h30
`define BWSR_OFS_BRIDGE_CTRL  8'h3c
`define BWSR_OFS_IRQ_STATUS   8'h40
`define BWSR_OFS_IRQ_MASK     8'h44

// ----------------------------------------------------------------------
// Field positions and constant codes.
// ----------------------------------------------------------------------
`define BWSR_IO_IND_CODE      4'h1
`define BWSR_PREF_64_CODE     4'h1
`define BWSR_SEC_PARITY_BIT   24
`define BWSR_SEC_TABORT_BIT   27
`define BWSR_SEC_RTABORT_BIT  28
`define BWSR_SEC_RMABORT_BIT  29
`define BWSR_SEC_SYSERR_BIT   30
`define BWSR_SEC_POISON_BIT   31
`define BWSR_BC_PERR_RESP_BIT 16
`define BWSR_BC_SERR_EN_BIT   17
`define BWSR_NUM_EVENTS       6

// ----------------------------------------------------------------------
// Reset values and implied low address bits.
// ----------------------------------------------------------------------
`define BWSR_IO_LIMIT_RST     4'h0
`define BWSR_IO_UPPER_RST     16'h0000
`define BWSR_MEM_FIELD_RST    12'h000
`define BWSR_EVT_RST          6'h00
`define BWSR_IO_LOW_ONES      12'hfff
`define BWSR_MEM_LOW_ONES     20'hfffff
`define BWSR_MEM_LOW_ZEROS    20'h00000

`endif

// ---- hw/bwsr_pkg.sv ----
`default_nettype none

package bwsr_pkg;

    // Transaction address presented for a forwarding decision.
    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic [63:0] addr;
    } bwsr_req_t;

    // Registered forwarding decision, one flag per window.
    typedef struct packed {
        logic valid;
        logic io_hit;
        logic mem_hit;
        logic pf_hit;
    } bwsr_fwd_t;

    // Secondary-side error events, each a one-cycle pulse.
    typedef struct packed {
        logic poison_rcvd;
        logic err_msg_sent;
        logic unsup_rcvd;
        logic cpl_abort_rcvd;
        logic cpl_abort_sent;
        logic parity_err;
    } bwsr_evt_t;

endpackage

`default_nettype wire

// ---- hw/bwsr_range_cmp.sv ----
`default_nettype none

module bwsr_range_cmp #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] addr_in,
    input  wire logic [W-1:0] base_in,
    input  wire logic [W-1:0] limit_in,
    output logic              hit_out
);

    // ------------------------------------------------------------------
    // Inclusive window check.
    // ------------------------------------------------------------------
    // A base above the limit gives an empty window, which is how
    // software switches a window off.
    assign hit_out = (addr_in >= base_in) && (addr_in <= limit_in);

endmodule

`default_nettype wire

// ---- hw/bwsr_regs.sv ----
`include "bwsr_defines.svh"
`default_nettype none

module bwsr_regs (
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // Register port.
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic [31:0]       reg_wdata_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    output logic      [31:0]       reg_rdata_out,
    // Window fields kept by neighbouring register blocks.
    input  wire logic [31:0]       io_base_in,
    input  wire logic [31:0]       pf_base_upper_in,
    input  wire logic [63:0]       pf_limit_in,
    // Secondary-side events.
    input  wire bwsr_pkg::bwsr_evt_t evt_in,
    // Forwarding decision.
    input  wire bwsr_pkg::bwsr_req_t req_in,
    output bwsr_pkg::bwsr_fwd_t    fwd_out,
    // Control levels for the datapath.
    output logic                   perr_resp_en_out,
    output logic                   serr_en_out,
    output logic                   irq_out
);
    import bwsr_pkg::*;

    // ------------------------------------------------------------------
    // Storage.
    // ------------------------------------------------------------------
    // Only the writable bits of each field are kept; constant codes,
    // reserved bits and the implied low address bits are built where
    // they are read, which keeps the flop count to what software owns.
    logic [3:0]  io_limit_ff;
    logic [15:0] io_upper_ff;
    logic [11:0] mem_base_ff;
    logic [11:0] mem_limit_ff;
    logic [11:0] pf_base_ff;
    logic        perr_resp_ff;
    logic        serr_en_ff;
    logic [5:0]  irq_mask_ff;
    logic [31:0] rdata_ff;
    bwsr_fwd_t   fwd_ff;

    logic [31:0] nxt_rdata;
    bwsr_fwd_t   nxt_fwd;

    // ------------------------------------------------------------------
    // Address decode.
    // ------------------------------------------------------------------
    // Full-address compares give every unmapped offset a zero read and
    // make writes there harmless.
    wire sel_io_sec  = (reg_addr_in == `BWSR_OFS_IO_SEC);
    wire sel_mem     = (reg_addr_in == `BWSR_OFS_MEM);
    wire sel_pref    = (reg_addr_in == `BWSR_OFS_PREF);
    wire sel_io_up   = (reg_addr_in == `BWSR_OFS_IO_UPPER);
    wire sel_bctl    = (reg_addr_in == `BWSR_OFS_BRIDGE_CTRL);
    wire sel_irq_st  = (reg_addr_in == `BWSR_OFS_IRQ_STATUS);
    wire sel_irq_msk = (reg_addr_in == `BWSR_OFS_IRQ_MASK);

    wire wr_io_sec  = reg_wr_in & sel_io_sec;
    wire wr_mem     = reg_wr_in & sel_mem;
    wire wr_pref    = reg_wr_in & sel_pref;
    wire wr_io_up   = reg_wr_in & sel_io_up;
    wire wr_bctl    = reg_wr_in & sel_bctl;
    wire wr_irq_st  = reg_wr_in & sel_irq_st;
    wire wr_irq_msk = reg_wr_in & sel_irq_msk;

    // ------------------------------------------------------------------
    // Event qualification.
    // ------------------------------------------------------------------
    // Event vector order: 0 parity, 1 abort sent, 2 abort received,
    // 3 unsupported received, 4 error message, 5 poison received.
    // The gates use the enable as it stood before the event edge, so an
    // event that arrives with the very write that turns its enable on is
    // dropped; the datapath sees the same registered enable and agrees.
    wire evt_parity = evt_in.parity_err & perr_resp_ff;
    wire evt_poison = evt_in.poison_rcvd & perr_resp_ff;
    wire evt_syserr = evt_in.err_msg_sent & serr_en_ff;

    wire [5:0] evt_vec = {
        evt_poison,
        evt_syserr,
        evt_in.unsup_rcvd,
        evt_in.cpl_abort_rcvd,
        evt_in.cpl_abort_sent,
        evt_parity
    };

    // Only the three write-one-clear positions take a software clear; the
    // read-only abort flags hold until reset.
    wire [5:0] sec_clr = wr_io_sec ? {
        reg_wdata_in[`BWSR_SEC_POISON_BIT],
        reg_wdata_in[`BWSR_SEC_SYSERR_BIT],
        3'b000,
        reg_wdata_in[`BWSR_SEC_PARITY_BIT]
    } : 6'h00;

    wire [5:0] irq_clr = wr_irq_st ? reg_wdata_in[5:0] : 6'h00;

    wire [5:0] sec_flags;
    wire [5:0] irq_flags;

    // ------------------------------------------------------------------
    // Sticky flag banks.
    // ------------------------------------------------------------------
    // Two banks take the same events so that software can clear the
    // interrupt copy without losing the status bits, and the other way
    // round; the read-only abort flags in the status bank see no clear
    // at all.
    // Secondary status flags: set wins over a clear in the same cycle.
    bwsr_sticky #(
        .W (`BWSR_NUM_EVENTS)
    ) u_sec_flags (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (evt_vec),
        .clr_in     (sec_clr),
        .q_out      (sec_flags)
    );

    // Interrupt status flags, cleared independently of the status word.
    bwsr_sticky #(
        .W (`BWSR_NUM_EVENTS)
    ) u_irq_flags (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .set_in     (evt_vec),
        .clr_in     (irq_clr),
        .q_out      (irq_flags)
    );

    // ------------------------------------------------------------------
    // Writable fields.
    // ------------------------------------------------------------------
    // Window field updates; constant and reserved bits are never stored.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            io_limit_ff  <= `BWSR_IO_LIMIT_RST;
            mem_base_ff  <= `BWSR_MEM_FIELD_RST;
            mem_limit_ff <= `BWSR_MEM_FIELD_RST;
            pf_base_ff   <= `BWSR_MEM_FIELD_RST;
            io_upper_ff  <= `BWSR_IO_UPPER_RST;
        end else begin
            if (wr_io_sec) begin
                io_limit_ff <= reg_wdata_in[15:12];
            end
            if (wr_mem) begin
                mem_base_ff  <= reg_wdata_in[15:4];
                mem_limit_ff <= reg_wdata_in[31:20];
            end
            if (wr_pref) begin
                pf_base_ff <= reg_wdata_in[15:4];
            end
            if (wr_io_up) begin
                io_upper_ff <= reg_wdata_in[31:16];
            end
        end
    end

    // Only the two enables used here are stored; the rest of the bridge
    // control word belongs to a neighbouring block and reads as zero.
    // Bridge control bits and the interrupt mask.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            perr_resp_ff <= 1'b0;
            serr_en_ff   <= 1'b0;
            irq_mask_ff  <= `BWSR_EVT_RST;
        end else begin
            if (wr_bctl) begin
                perr_resp_ff <= reg_wdata_in[`BWSR_BC_PERR_RESP_BIT];
                serr_en_ff   <= reg_wdata_in[`BWSR_BC_SERR_EN_BIT];
            end
            if (wr_irq_msk) begin
                irq_mask_ff <= reg_wdata_in[5:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Read words.
    // ------------------------------------------------------------------
    // Status word: legacy capability and timing bits and reserved bits
    // are tied to zero, so writes to them have nothing to land in.
    wire [31:0] word_io_sec = {
        sec_flags[5],
        sec_flags[4],
        sec_flags[3],
        sec_flags[2],
        sec_flags[1],
        2'b00,
        sec_flags[0],
        1'b0,
        1'b0,
        1'b0,
        5'h00,
        io_limit_ff,
        `BWSR_IO_IND_CODE,
        8'h00
    };

    wire [31:0] word_mem = {mem_limit_ff, 4'h0, mem_base_ff, 4'h0};

    wire [31:0] word_pref = {16'h0000, pf_base_ff, `BWSR_PREF_64_CODE};

    wire [31:0] word_io_up = {io_upper_ff, 16'h0000};

    wire [31:0] word_bctl = {14'h0000, serr_en_ff, perr_resp_ff, 16'h0000};

    wire [31:0] word_irq_st  = {26'h0000000, irq_flags};
    wire [31:0] word_irq_msk = {26'h0000000, irq_mask_ff};

    // The strobe gates the word before it is registered, so the read data
    // fall back to zero one cycle after each read and a held address
    // never leaks a stale value onto the port.
    // One-hot select; anything unmapped reads as zero.
    assign nxt_rdata = !reg_rd_in  ? 32'h00000000 :
                       sel_io_sec  ? word_io_sec  :
                       sel_mem     ? word_mem     :
                       sel_pref    ? word_pref    :
                       sel_io_up   ? word_io_up   :
                       sel_bctl    ? word_bctl    :
                       sel_irq_st  ? word_irq_st  :
                       sel_irq_msk ? word_irq_msk : 32'h00000000;

    // Read data stand for exactly the cycle after the strobe.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Window assembly.
    // ------------------------------------------------------------------
    // The implied low bits make the limits inclusive of a whole granule.
    wire [31:0] io_limit_full  = {io_upper_ff, io_limit_ff, `BWSR_IO_LOW_ONES};
    wire [31:0] mem_base_full  = {mem_base_ff, `BWSR_MEM_LOW_ZEROS};
    wire [31:0] mem_limit_full = {mem_limit_ff, `BWSR_MEM_LOW_ONES};
    wire [63:0] pf_base_full   = {pf_base_upper_in, pf_base_ff,
                                  `BWSR_MEM_LOW_ZEROS};

    wire io_in_range;
    wire mem_in_range;
    wire pf_in_range;

    // ------------------------------------------------------------------
    // Window comparators.
    // ------------------------------------------------------------------
    // Each window has its own comparator pair, so all three decisions are
    // made in the same cycle; the price is six wide magnitude compares.
    // The I/O window ignores address bits above 31, since I/O addressing
    // here is only 32 bits wide.
    // I/O window on the low 32 address bits.
    bwsr_range_cmp #(
        .W (32)
    ) u_io_cmp (
        .addr_in  (req_in.addr[31:0]),
        .base_in  (io_base_in),
        .limit_in (io_limit_full),
        .hit_out  (io_in_range)
    );

    // Non-prefetchable window on the low 32 address bits.
    bwsr_range_cmp #(
        .W (32)
    ) u_mem_cmp (
        .addr_in  (req_in.addr[31:0]),
        .base_in  (mem_base_full),
        .limit_in (mem_limit_full),
        .hit_out  (mem_in_range)
    );

    // Prefetchable window across the full 64-bit address.
    bwsr_range_cmp #(
        .W (64)
    ) u_pf_cmp (
        .addr_in  (req_in.addr),
        .base_in  (pf_base_full),
        .limit_in (pf_limit_in),
        .hit_out  (pf_in_range)
    );

    // ------------------------------------------------------------------
    // Forwarding decision.
    // ------------------------------------------------------------------
    // The non-prefetchable window only reaches 4 GB, so any address with
    // upper bits set misses it even when the low bits fall inside.
    wire addr_below_4g = (req_in.addr[63:32] == 32'h00000000);

    // A request marked as I/O is only matched against the I/O window and
    // a memory request only against the two memory windows; both memory
    // windows may hit at once when software lets them overlap.
    assign nxt_fwd.valid   = req_in.valid;
    assign nxt_fwd.io_hit  = req_in.valid & req_in.is_io & io_in_range;
    assign nxt_fwd.mem_hit = req_in.valid & ~req_in.is_io & addr_below_4g
                             & mem_in_range;
    assign nxt_fwd.pf_hit  = req_in.valid & ~req_in.is_io & pf_in_range;

    // Registered so the decision is a clean flop output one cycle later.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            fwd_ff <= '0;
        end else begin
            fwd_ff <= nxt_fwd;
        end
    end

    // ------------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------------
    // Every data output comes straight from a flop; only the interrupt
    // level below is a small gate of flops, so it drops in the same cycle
    // in which a clearing write lands.
    assign reg_rdata_out    = rdata_ff;
    assign fwd_out          = fwd_ff;
    assign perr_resp_en_out = perr_resp_ff;
    assign serr_en_out      = serr_en_ff;

    // Masking only hides a flag from this output; the flag itself stays
    // set, so unmasking later raises the interrupt at once.
    // Level interrupt: high while any unmasked flag is set.
    assign irq_out = |(irq_flags & irq_mask_ff);

endmodule

`default_nettype wire

// ---- hw/bwsr_sticky.sv ----
`default_nettype none

module bwsr_sticky #(
    parameter int W = 6
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic [W-1:0] set_in,
    input  wire logic [W-1:0] clr_in,
    output logic      [W-1:0] q_out
);

    // ------------------------------------------------------------------
    // Sticky bits.
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // A set in the same cycle as a clear wins, so no event is lost.
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    q_out[i] <= 1'b0;
                end else begin
                    q_out[i] <= set_in[i] | (q_out[i] & ~clr_in[i]);
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// ---- tb/bwsr_regs_properties.sv ----
`default_nettype none

// ----------------------------------------------------------------
// Port checker for the window and secondary status register block.
// ----------------------------------------------------------------
module bwsr_regs_props (
    input  wire logic                clk_in,
    input  wire logic                sys_rst_in,
    input  wire logic [7:0]          reg_addr_in,
    input  wire logic [31:0]         reg_wdata_in,
    input  wire logic                reg_wr_in,
    input  wire logic                reg_rd_in,
    input  wire logic [31:0]         reg_rdata_out,
    input  wire logic [31:0]         io_base_in,
    input  wire logic [31:0]         pf_base_upper_in,
    input  wire logic [63:0]         pf_limit_in,
    input  wire bwsr_pkg::bwsr_evt_t evt_in,
    input  wire bwsr_pkg::bwsr_req_t req_in,
    input  wire bwsr_pkg::bwsr_fwd_t fwd_out,
    input  wire logic                perr_resp_en_out,
    input  wire logic                serr_en_out,
    input  wire logic                irq_out
);
    import bwsr_pkg::*;

    default clocking dclk @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    // A flag only rises through an event that its enable lets in, so with
    // no such event and no write the interrupt has no way to go high.
    logic no_cause;
    assign no_cause = !irq_out && !reg_wr_in && !evt_in.unsup_rcvd
        && !evt_in.cpl_abort_rcvd && !evt_in.cpl_abort_sent
        && !(perr_resp_en_out && (evt_in.parity_err || evt_in.poison_rcvd))
        && !(serr_en_out && evt_in.err_msg_sent);

    rdata_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == 32'h0)
        else $error("read data not zero outside a read");
    io_const_a: assert property (
        reg_rd_in && reg_addr_in == 8'h1c |=> reg_rdata_out[11:0] == 12'h100
            && reg_rdata_out[23:16] == 8'h00 && reg_rdata_out[26:25] == 2'h0)
        else $error("constant fields at 0x1c read wrong");
    pref_const_a: assert property (
        reg_rd_in && reg_addr_in == 8'h24 |=> reg_rdata_out[3:0] == 4'h1
            && reg_rdata_out[31:16] == 16'h0)
        else $error("constant fields at 0x24 read wrong");
    irq_gate_a: assert property (
        no_cause |=> !irq_out)
        else $error("interrupt rose without an enabled event");
    irq_hold_a: assert property (
        irq_out && !reg_wr_in |=> irq_out)
        else $error("interrupt fell without a write");
    fwd_idle_a: assert property (
        !req_in.valid |=> fwd_out == 4'h0)
        else $error("forward flags set without a request");
    fwd_valid_a: assert property (
        req_in.valid |=> fwd_out.valid)
        else $error("forward decision missing one cycle after request");
    io_kind_a: assert property (
        req_in.valid && req_in.is_io |=> !fwd_out.mem_hit && !fwd_out.pf_hit)
        else $error("io request hit a memory window");
    io_range_a: assert property (
        req_in.valid && req_in.is_io && req_in.addr[31:0] < io_base_in
            |=> !fwd_out.io_hit)
        else $error("io hit below the io base");
    mem_kind_a: assert property (
        req_in.valid && !req_in.is_io && req_in.addr[63:32] != 32'h0
            |=> !fwd_out.mem_hit && !fwd_out.io_hit)
        else $error("memory hit above 4 GB or io hit");
    pf_range_a: assert property (
        req_in.valid && !req_in.is_io && (req_in.addr > pf_limit_in
            || req_in.addr[63:32] < pf_base_upper_in) |=> !fwd_out.pf_hit)
        else $error("prefetch hit outside its window");
endmodule

bind bwsr_regs bwsr_regs_props u_bwsr_regs_props (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .io_base_in(io_base_in),
    .pf_base_upper_in(pf_base_upper_in), .pf_limit_in(pf_limit_in),
    .evt_in(evt_in), .req_in(req_in), .fwd_out(fwd_out),
    .perr_resp_en_out(perr_resp_en_out), .serr_en_out(serr_en_out), .irq_out(irq_out)
);

`default_nettype wire

// ---- tb/testbench.sv ----
`default_nettype none

// ----------------------------------------------------------------
// Testbench for the window and secondary status register block.
// ----------------------------------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import bwsr_pkg::*;

    logic        clk_in           = 1'b0;
    logic        sys_rst_in       = 1'b1;
    logic [7:0]  reg_addr_in      = 8'h00;
    logic [31:0] reg_wdata_in     = 32'h0;
    logic        reg_wr_in        = 1'b0;
    logic        reg_rd_in        = 1'b0;
    logic [31:0] reg_rdata_out;
    logic [31:0] io_base_in       = 32'h0001_0000;
    logic [31:0] pf_base_upper_in = 32'h0000_0001;
    logic [63:0] pf_limit_in      = 64'h1_ffff_ffff;
    bwsr_evt_t   evt_in           = '0;
    bwsr_req_t   req_in           = '0;
    bwsr_fwd_t   fwd_out;
    logic        perr_resp_en_out;
    logic        serr_en_out;
    logic        irq_out;
    int          err_count        = 0;
    int          checks           = 0;

    // Rows: address, value after reset, value after writing all ones.
    logic [71:0] rtab [0:7] = '{
        {8'h1c, 32'h0000_0100, 32'h0000_f100}, {8'h20, 32'h0, 32'hfff0_fff0},
        {8'h24, 32'h0000_0001, 32'h0000_fff1}, {8'h30, 32'h0, 32'hffff_0000},
        {8'h3c, 32'h0, 32'h0003_0000}, {8'h40, 32'h0, 32'h0},
        {8'h44, 32'h0, 32'h0000_003f}, {8'h50, 32'h0, 32'h0}};
    // Rows: is_io, address, expected {valid, io, mem, pf}; edges of each window.
    logic [68:0] ftab [0:12] = '{
        {1'b1, 64'h1_0000, 4'hc}, {1'b1, 64'h1_ffff, 4'hc}, {1'b1, 64'hffff, 4'h8},
        {1'b1, 64'h2_0000, 4'h8}, {1'b1, 64'h1_0001_0000, 4'hc},
        {1'b0, 64'h10_0000, 4'ha}, {1'b0, 64'h2f_ffff, 4'ha}, {1'b0, 64'h30_0000, 4'h8},
        {1'b0, 64'hf_ffff, 4'h8}, {1'b0, 64'h1_0010_0000, 4'h8},
        {1'b0, 64'h1_fff0_0000, 4'h9}, {1'b0, 64'h1_ffff_ffff, 4'h9},
        {1'b0, 64'h2_0000_0000, 4'h8}};

    bwsr_regs u_bwsr_regs (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .io_base_in(io_base_in),
        .pf_base_upper_in(pf_base_upper_in), .pf_limit_in(pf_limit_in),
        .evt_in(evt_in), .req_in(req_in), .fwd_out(fwd_out),
        .perr_resp_en_out(perr_resp_en_out), .serr_en_out(serr_en_out),
        .irq_out(irq_out));

    // Free-running 25 MHz clock.
    always #20 clk_in = ~clk_in;

    // Compares with case equality so an unknown never passes.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; a gap cycle follows so no strobe is set twice.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge clk_in);
        reg_rd_in   <= 1'b0;
        #1;
        chk(reg_rdata_out, exp);
    endtask

    // One-cycle event pulse; returns once its flags have landed.
    task automatic pulse(input logic [5:0] e);
        @(posedge clk_in);
        evt_in <= e;
        @(posedge clk_in);
        evt_in <= '0;
        #1;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Watchdog: a hung run counts as a failure.
    initial begin
        #200000;
        err_count++;
        summarize();
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(rtab[i][71:64], rtab[i][63:32]);
        end
        chk(32'({irq_out, fwd_out, serr_en_out, perr_resp_en_out}), 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 8; i++) begin
            wr(rtab[i][71:64], 32'hffff_ffff);
            rd(rtab[i][71:64], rtab[i][31:0]);
        end
        $display("test write_all_ones done");
        wr(8'h3c, 32'h0);
        wr(8'h44, 32'h0);
        wr(8'h20, 32'h0020_0010);
        wr(8'h30, 32'h0001_0000);
        // Parity and poison gated off, error message gated off, mask clear.
        pulse(6'h3f);
        chk(32'(irq_out), 32'h0);
        rd(8'h1c, 32'h3800_f100);
        rd(8'h40, 32'h0000_000e);
        wr(8'h44, 32'h0000_003f);
        #1;
        chk(32'(irq_out), 32'h1);
        wr(8'h40, 32'h0000_0002);
        rd(8'h40, 32'h0000_000c);
        wr(8'h40, 32'h0000_000c);
        #1;
        chk(32'(irq_out), 32'h0);
        // Now with both enables on every event must leave its mark.
        wr(8'h3c, 32'h0003_0000);
        #1;
        chk(32'({serr_en_out, perr_resp_en_out}), 32'h3);
        pulse(6'h3f);
        chk(32'(irq_out), 32'h1);
        rd(8'h1c, 32'hf900_f100);
        rd(8'h40, 32'h0000_003f);
        wr(8'h1c, 32'hffff_f000);
        rd(8'h1c, 32'h3800_f100);
        chk(32'(irq_out), 32'h1);
        wr(8'h40, 32'h0000_003f);
        #1;
        chk(32'(irq_out), 32'h0);
        // One event at a time: bit order, and the system error gate alone.
        wr(8'h3c, 32'h0001_0000);
        #1;
        chk(32'({serr_en_out, perr_resp_en_out}), 32'h1);
        for (int j = 0; j < 6; j++) begin
            pulse(6'h01 << j);
            chk(32'(irq_out), 32'(j != 4));
            rd(8'h40, (j == 4) ? 32'h0 : 32'h1 << j);
            rd(8'h1c, {j == 5, 1'b0, 3'h7, 2'h0, j == 0, 24'h00_f100});
            wr(8'h40, 32'h0000_003f);
            wr(8'h1c, 32'hc100_f000);
        end
        // A clear that lands in the same cycle as its event must lose.
        @(posedge clk_in);
        evt_in       <= 6'h20;
        reg_addr_in  <= 8'h40;
        reg_wdata_in <= 32'h0000_0020;
        reg_wr_in    <= 1'b1;
        @(posedge clk_in);
        evt_in       <= '0;
        reg_wr_in    <= 1'b0;
        rd(8'h40, 32'h0000_0020);
        wr(8'h40, 32'h0000_0020);
        #1;
        chk(32'(irq_out), 32'h0);
        $display("test events done");
        // Back-to-back requests at the edges of each window.
        for (int i = 0; i <= 13; i++) begin
            @(posedge clk_in);
            if (i < 13) begin
                req_in <= {1'b1, ftab[i][68:4]};
            end else begin
                req_in <= '0;
            end
            if (i > 0) begin
                #1;
                chk(32'(fwd_out), 32'(ftab[i-1][3:0]));
            end
        end
        @(posedge clk_in);
        #1;
        chk(32'(fwd_out), 32'h0);
        $display("test forwarding done");
        summarize();
    end
endmodule

`default_nettype wire
